// ===== shared/capture_defs.svh
// Purpose: constants of the pulse sample capture block
// Assumes: 50 MHz system clock
// Notes:   offsets are APB byte addresses
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH
// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS  20
`define FREE_RUN_NS    21200
`define FREE_RUN_CYC   ((`FREE_RUN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PREAMBLE_US    120
`define PREAMBLE_CYC   (`PREAMBLE_US * 1000 / `CLK_PERIOD_NS)
// Fractional rate generators: tick = clk * inc / mod
`define REF_MOD        8'h32
`define REF_INC        8'h10
`define QCLK_MOD       8'h91
`define QCLK_INC_24    8'h30
`define QCLK_INC_26    8'h34
`define QCLK_INC_28    8'h38
// ************************************************************
// Buffer and records
// ************************************************************
`define BUF_DEPTH      10'h200
`define TAG_PULSE      2'h0
`define TAG_SWEEP      2'h1
`define TAG_HEADER     2'h2
// ************************************************************
// Registers
// ************************************************************
`define REG_CTRL       8'h00
`define REG_INTERVAL   8'h04
`define REG_REP        8'h08
`define REG_PARAM      8'h0C
`define REG_STATUS     8'h10
`define REG_TOD        8'h14
`define REG_DATA_LO    8'h18
`define REG_DATA_HI    8'h1C
`define CTRL_RUN       0
`define CTRL_FREE      1
`define STAT_OVF       16
`define INTERVAL_RST   16'h0640
`define REP_RST        20'h0_3E80
`endif

// ===== shared/capture_pkg.sv
// Purpose: types of the pulse sample capture block
// Assumes: nothing
// Notes:   all records are 64 bits wide
package capture_pkg;
  typedef enum logic [1:0] {WIN_IDLE, WIN_EDGE, WIN_PREAMBLE} win_mode_t;
  typedef struct packed {
    logic [5:0] disc;
    logic [7:0] err;
    logic [6:0] omni;
    logic [6:0] sum;
  } conv_samples_t;
  typedef struct packed {
    logic [1:0]    tag;
    logic          pseudo;
    logic [7:0]    width;
    logic [15:0]   range;
    conv_samples_t samp;
    logic [8:0]    pad;
  } pulse_entry_t;
  typedef struct packed {
    logic [1:0]  tag;
    logic [6:0]  pad;
    logic        azBackup;
    logic [5:0]  mode;
    logic [15:0] az;
    logic [31:0] time_of_day_generator;
  } sweep_entry_t;
  typedef struct packed {
    logic [7:0] acc;
    logic       tick;
  } rate_state_t;
  typedef struct packed {
    win_mode_t    winMode;
    logic [12:0]  winCnt;
    logic         convPend;
    logic         strobeTgl;
    logic         videoPrev;
    logic [7:0]   widthCnt;
    logic [15:0]  rangeCnt;
    logic         rangeRun;
    logic [15:0]  latRange;
    logic         latPseudo;
    logic         capPend;
    logic         trigPend;
    logic         trigS1;
    logic         trigS2;
    logic         trigS3;
    logic [19:0]  repCnt;
    logic [31:0]  time_of_day_generator;
    logic         sweepPend;
    sweep_entry_t sweepRec;
    logic         hdrPend;
    logic [31:0]  hdrParam;
    logic [8:0]   wrPtr;
    logic [8:0]   rdPtr;
    logic [9:0]   count;
    logic         overflow;
    logic         run;
    logic         freeMode;
    logic [1:0]   qSel;
    logic [15:0]  interval;
    logic [19:0]  repPeriod;
    logic [31:0]  prdata;
    logic         pslverr;
    logic         encode;
    logic         zrOut;
    logic         leadOut;
    logic         pseudoOut;
  } capture_state_t;
endpackage

// ===== rtl/rate_enable.sv
// Purpose: fractional clock enable, average rate clk*incr/modulus
// Assumes: incr below modulus
// Notes:   ticks are single cycles, jitter one clk period
`timescale 1ns/10ps
`include "capture_defs.svh"
module rate_enable import capture_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] incr,
  input  wire logic [7:0] modulus,
  output logic            tick
);
  rate_state_t s;
  rate_state_t n;
  logic [8:0]  sum;

  always_comb begin
    sum = {1'b0, s.acc} + {1'b0, incr};
    n = s;
    n.tick = 1'b0;
    if (sum >= {1'b0, modulus}) begin
      n.acc = 8'(sum - {1'b0, modulus});
      n.tick = 1'b1;
    end else begin
      n.acc = sum[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) s <= '0;
    else s <= n;
  end

  assign tick = s.tick;

  chk_acc_bound: assert property (@(posedge clk) disable iff (!rst_b)
    (incr < modulus) |=> (s.acc < $past(modulus)))
    else $error("rate accumulator left its range");
endmodule // rate_enable

// ===== rtl/pulse_sample_capture.sv
// Purpose: sample control and capture buffer of the reply digitizer
// Assumes: converter data valid the cycle after encodeStrobe
// Notes:   APB slave, zero wait states, buffer drained by software
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "capture_defs.svh"
module pulse_sample_capture import capture_pkg::*; #(
  parameter int PREAMBLE_WIN_CYC = `PREAMBLE_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          quantizedSumVideo,
  input  wire logic          snrOk,
  input  wire logic          riseOk,
  input  wire logic          overlapStep,
  input  wire logic          preambleHit,
  input  wire conv_samples_t convData,
  input  wire logic [13:0]   azPrimary,
  input  wire logic          azPrimaryValid,
  input  wire logic [15:0]   azSynchro,
  input  wire logic [5:0]    xmitMode,
  output logic               encodeStrobe,
  output logic               zeroRangeTrig,
  output logic               leadEdgeDecl,
  output logic               pseudoEdgeDecl
);
  // ************************************************************
  // Declarations
  // ************************************************************
  capture_state_t s;
  capture_state_t n;
  logic [63:0]    bufMem [0:511];
  logic [63:0]    headWord;
  logic           memWrEn;
  logic [63:0]    memWrData;
  logic [7:0]     incArr [0:1];
  logic [7:0]     modArr [0:1];
  logic [1:0]     tickArr;
  logic           tick16;
  logic           qTick;
  logic           strobeEn;
  logic           leadEdge;
  logic           pseudoEdge;
  logic           winAct;
  logic           zrTrig;
  logic           apbSetup;
  logic           apbAccess;
  logic           pop;
  logic           wrReq;
  logic           bufFull;
  pulse_entry_t   pulseRec;
  logic [7:0]     qInc;

  function automatic logic regHit(input logic [7:0] a,
                                  input logic [7:0] off);
    regHit = (a == off);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `REG_DATA_HI);
  endfunction

  // ************************************************************
  // Rate enables
  // ************************************************************
  always_comb begin
    case (s.qSel)
      2'h1:    qInc = `QCLK_INC_26;
      2'h2:    qInc = `QCLK_INC_28;
      default: qInc = `QCLK_INC_24;
    endcase
  end

  assign incArr[0] = `REF_INC;
  assign modArr[0] = `REF_MOD;
  assign incArr[1] = qInc;
  assign modArr[1] = `QCLK_MOD;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rate
      rate_enable u_rate (
        .clk     (clk),
        .rst_b   (rst_b),
        .incr    (incArr[gi]),
        .modulus (modArr[gi]),
        .tick    (tickArr[gi])
      );
    end
  endgenerate

  assign tick16 = tickArr[0];
  assign qTick = tickArr[1];
  // Only every second quantizer tick may strobe
  assign strobeEn = qTick & s.strobeTgl;

  // ************************************************************
  // Quantizer edges and window
  // ************************************************************
  assign leadEdge = s.run & qTick & quantizedSumVideo & !s.videoPrev
                  & snrOk & riseOk;
  assign pseudoEdge = s.run & qTick & quantizedSumVideo & s.videoPrev
                    & overlapStep & snrOk & riseOk;
  assign winAct = (s.winMode != WIN_IDLE);
  assign zrTrig = tick16 & s.run & (s.repCnt >= s.repPeriod - 20'h1);
  assign apbSetup = psel & !penable;
  assign apbAccess = psel & penable;
  assign pop = apbAccess & !pwrite & regHit(paddr, `REG_DATA_HI)
             & (s.count != 10'h000);
  assign bufFull = (s.count == `BUF_DEPTH);
  assign headWord = bufMem[s.rdPtr];

  always_comb begin
    pulseRec.tag = `TAG_PULSE;
    pulseRec.pseudo = s.latPseudo;
    pulseRec.width = s.widthCnt;
    pulseRec.range = s.latRange;
    pulseRec.samp = convData;
    pulseRec.pad = '0;
  end

  always_comb begin
    n = s;
    memWrEn = 1'b0;
    memWrData = '0;
    wrReq = 1'b0;
    n.leadOut = leadEdge;
    n.pseudoOut = pseudoEdge;
    n.zrOut = zrTrig;
    n.encode = 1'b0;
    n.capPend = s.encode;
    if (qTick) begin
      n.videoPrev = quantizedSumVideo;
      n.strobeTgl = !s.strobeTgl;
      if (leadEdge) n.widthCnt = 8'h01;
      else if (quantizedSumVideo && s.widthCnt != 8'hFF)
        n.widthCnt = s.widthCnt + 8'h01;
    end
    if (leadEdge || pseudoEdge) begin
      n.latRange = s.rangeCnt;
      n.latPseudo = pseudoEdge;
    end
    case (s.winMode)
      WIN_IDLE: begin
        if (preambleHit && s.run) begin
          n.winMode = WIN_PREAMBLE;
          n.winCnt = 13'(PREAMBLE_WIN_CYC);
        end else if (leadEdge && s.freeMode) begin
          n.winMode = WIN_EDGE;
          n.winCnt = 13'(`FREE_RUN_CYC);
        end
      end
      WIN_EDGE, WIN_PREAMBLE: begin
        // A preamble extends an edge window; edges never do
        if (preambleHit && s.run && s.winMode == WIN_EDGE) begin
          n.winMode = WIN_PREAMBLE;
          n.winCnt = 13'(PREAMBLE_WIN_CYC);
        end else if (s.winCnt <= 13'h0001) begin
          n.winMode = WIN_IDLE;
          n.winCnt = '0;
        end else begin
          n.winCnt = s.winCnt - 13'h0001;
        end
      end
      default: begin
        n.winMode = WIN_IDLE;
        n.winCnt = '0;
      end
    endcase
    if (strobeEn) begin
      if (winAct) n.encode = 1'b1;
      else if (s.convPend) begin
        n.encode = 1'b1;
        n.convPend = 1'b0;
      end
    end
    // Set after clear: an edge on the strobe cycle is kept
    if ((leadEdge || pseudoEdge) && !s.freeMode && !winAct)
      n.convPend = 1'b1;

    // **********************************************************
    // Repetition, time of day, range
    // **********************************************************
    if (tick16) begin
      n.time_of_day_generator = s.time_of_day_generator + 32'h0000_0001;
      if (s.run) n.repCnt = zrTrig ? 20'h0_0000 : s.repCnt + 20'h0_0001;
    end
    if (qTick) begin
      if (s.trigS2) n.trigPend = 1'b0;
      n.trigS1 = s.trigPend;
      n.trigS2 = s.trigS1;
      n.trigS3 = s.trigS2;
      if (s.trigS2 && !s.trigS3) begin
        n.rangeCnt = '0;
        n.rangeRun = 1'b1;
      end else if (s.rangeRun) begin
        if (s.rangeCnt >= s.interval) n.rangeRun = 1'b0;
        else n.rangeCnt = s.rangeCnt + 16'h0001;
      end
    end
    if (zrTrig) begin
      n.trigPend = 1'b1;
      n.sweepPend = 1'b1;
      n.sweepRec.tag = `TAG_SWEEP;
      n.sweepRec.pad = '0;
      n.sweepRec.mode = xmitMode;
      n.sweepRec.time_of_day_generator = s.time_of_day_generator;
      n.sweepRec.azBackup = !azPrimaryValid;
      n.sweepRec.az = azPrimaryValid ? {azPrimary, 2'h0}
                                     : azSynchro;
    end

    // **********************************************************
    // APB slave
    // **********************************************************
    if (apbSetup) begin
      n.pslverr = !mapped(paddr);
      case (paddr)
        `REG_CTRL:     n.prdata = {28'h000_0000, s.qSel, s.freeMode, s.run};
        `REG_INTERVAL: n.prdata = {16'h0000, s.interval};
        `REG_REP:      n.prdata = {12'h000, s.repPeriod};
        `REG_PARAM:    n.prdata = s.hdrParam;
        `REG_STATUS:   n.prdata = {15'h0000, s.overflow, 5'h00, winAct,
                                   s.count};
        `REG_TOD:      n.prdata = s.time_of_day_generator;
        `REG_DATA_LO:  n.prdata = headWord[31:0];
        `REG_DATA_HI:  n.prdata = headWord[63:32];
        default:       n.prdata = 32'h0000_0000;
      endcase
    end
    if (apbAccess && pwrite && mapped(paddr)) begin
      if (regHit(paddr, `REG_CTRL)) begin
        n.run = pwdata[`CTRL_RUN];
        n.freeMode = pwdata[`CTRL_FREE];
        n.qSel = pwdata[3:2];
      end
      if (regHit(paddr, `REG_INTERVAL)) n.interval = pwdata[15:0];
      if (regHit(paddr, `REG_REP)) n.repPeriod = pwdata[19:0];
      if (regHit(paddr, `REG_PARAM)) begin
        n.hdrParam = pwdata;
        n.hdrPend = 1'b1;
      end
      if (regHit(paddr, `REG_STATUS) && pwdata[`STAT_OVF])
        n.overflow = 1'b0;
    end
    if (pop) n.rdPtr = s.rdPtr + 9'h001;

    // **********************************************************
    // Buffer writes: pulse first, it cannot wait
    // **********************************************************
    if (s.capPend) begin
      wrReq = 1'b1;
      memWrData = pulseRec;
    end else if (s.hdrPend) begin
      wrReq = 1'b1;
      // A PARAM write in this cycle queues a fresh header
      n.hdrPend = apbAccess & pwrite & regHit(paddr, `REG_PARAM);
      memWrData = {`TAG_HEADER, 30'h0000_0000, s.hdrParam};
    end else if (s.sweepPend) begin
      wrReq = 1'b1;
      n.sweepPend = zrTrig;
      memWrData = s.sweepRec;
    end
    if (wrReq) begin
      if (bufFull) n.overflow = 1'b1;
      else begin
        memWrEn = 1'b1;
        n.wrPtr = s.wrPtr + 9'h001;
      end
    end
    n.count = s.count + {9'h000, memWrEn} - {9'h000, pop};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
      s.interval <= `INTERVAL_RST;
      s.repPeriod <= `REP_RST;
    end else begin
      s <= n;
    end
  end

  // One word per clock: far above one byte per 45 ns
  always_ff @(posedge clk) begin
    if (memWrEn) bufMem[s.wrPtr] <= memWrData;
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = s.pslverr & apbAccess;
  assign encodeStrobe = s.encode;
  assign zeroRangeTrig = s.zrOut;
  assign leadEdgeDecl = s.leadOut;
  assign pseudoEdgeDecl = s.pseudoOut;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_edge_decl: assert property (
    leadEdge |=> leadEdgeDecl && !pseudoEdgeDecl)
    else $error("leading edge not declared");
  chk_single_encode: assert property (
    encodeStrobe |=> !encodeStrobe)
    else $error("encode strobe longer than one cycle");
  chk_edge_strobe: assert property (
    strobeEn && s.convPend && !winAct |=> encodeStrobe ##1 s.capPend)
    else $error("pending edge not strobed");
  chk_free_start: assert property (
    s.winMode == WIN_IDLE && leadEdge && s.freeMode && !preambleHit
    |=> s.winCnt == 13'(`FREE_RUN_CYC) && s.winMode == WIN_EDGE)
    else $error("free run window not started");
  chk_no_restart: assert property (
    s.winMode == WIN_EDGE && s.winCnt > 13'h0001 && !preambleHit
    |=> s.winCnt == $past(s.winCnt) - 13'h0001)
    else $error("free run window restarted");
  chk_range_latch: assert property (
    (leadEdge || pseudoEdge) |=> s.latRange == $past(s.rangeCnt))
    else $error("range count not latched");
  chk_preamble_win: assert property (
    s.winMode == WIN_IDLE && preambleHit && s.run
    |=> s.winMode == WIN_PREAMBLE && s.winCnt == 13'(PREAMBLE_WIN_CYC))
    else $error("preamble window not started");
  chk_pulse_write: assert property (
    s.capPend && !bufFull |-> memWrEn && memWrData[63:62] == `TAG_PULSE)
    else $error("pulse entry not written");
  chk_buf_bound: assert property (
    s.count <= `BUF_DEPTH)
    else $error("buffer count beyond depth");
  chk_sweep_rec: assert property (
    zrTrig ##1 !bufFull[*2] |-> ##[0:3] !s.sweepPend)
    else $error("sweep record not written");
  chk_range_clear: assert property (
    qTick && s.trigS2 && !s.trigS3 |=> s.rangeCnt == 16'h0000)
    else $error("range not cleared on trigger");
  chk_half_rate: assert property (
    encodeStrobe |-> !s.strobeTgl)
    else $error("strobe off the half rate");

  cov_edge_mode: cover property (leadEdge && !s.freeMode ##[1:20]
    encodeStrobe);
  cov_free_run: cover property (s.winMode == WIN_EDGE && s.winCnt ==
    13'h0001);
  cov_preamble: cover property (s.winMode == WIN_IDLE ##1
    s.winMode == WIN_PREAMBLE);
  cov_overflow: cover property ($rose(s.overflow));
endmodule // pulse_sample_capture

// ===== bench/conv_model.sv
// Purpose: converter bank answering encode strobes of the capture block
// Assumes: capture block samples convData the cycle after encodeStrobe
// Notes:   outside that cycle the bus shows inverted data, never a hold
`timescale 1ns/10ps
module conv_model import capture_pkg::*; (
  input  wire logic    clk,
  input  wire logic    rst_b,
  input  wire logic    encodeStrobe,
  output conv_samples_t convData
);
  logic [27:0] lfsrReg;

  // ****************************************************************
  // Sample generation
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lfsrReg  <= 28'h0AB_CDEF;
      convData <= '0;
    end else if (encodeStrobe) begin
      lfsrReg  <= {lfsrReg[26:0], lfsrReg[27] ^ lfsrReg[24]};
      convData <= lfsrReg;
    end else begin
      // Bus released: unknowns would settle silently, so invert instead
      convData <= ~convData;
    end
  end
endmodule // conv_model

// ===== bench/tb_top.sv
// Purpose: self-checking bench of the pulse sample capture block
// Assumes: zero wait APB slave, short preamble window for simulation
// Notes:   software role drains the buffer as the recorder would
`timescale 1ns/10ps
`include "capture_defs.svh"
module tb_top import capture_pkg::*;;
  logic          clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd, param, seed;
  logic          quantizedSumVideo, snrOk, riseOk, overlapStep;
  logic          preambleHit, azPrimaryValid, strobeD;
  conv_samples_t convData;
  logic [13:0]   azPrimary;
  logic [15:0]   azSynchro;
  logic [5:0]    xmitMode;
  logic [1:0]    qSel;
  logic          encodeStrobe, zeroRangeTrig, leadEdgeDecl, pseudoEdgeDecl;
  logic [64:0]   expE;
  logic [64:0]   expQ[$];
  conv_samples_t sampQ[$];
  int            n_errors, cmp_count, nStrobe, nLead, nPseudo, s0, l0;
  int            cyc, zrLast, zrGap, nZr;

  pulse_sample_capture #(.PREAMBLE_WIN_CYC(200)) u_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .quantizedSumVideo(quantizedSumVideo), .snrOk(snrOk), .riseOk(riseOk),
    .overlapStep(overlapStep), .preambleHit(preambleHit),
    .convData(convData), .azPrimary(azPrimary),
    .azPrimaryValid(azPrimaryValid), .azSynchro(azSynchro),
    .xmitMode(xmitMode), .encodeStrobe(encodeStrobe),
    .zeroRangeTrig(zeroRangeTrig), .leadEdgeDecl(leadEdgeDecl),
    .pseudoEdgeDecl(pseudoEdgeDecl));

  conv_model u_conv (.clk(clk), .rst_b(rst_b), .encodeStrobe(encodeStrobe),
    .convData(convData));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] m, input logic [31:0] x,
      input logic er);
    expQ.push_back({er, m, x});
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel    <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  // Overlap step held until its declaration shows: quantizer ticks
  // are never closer than two clocks, so exactly one pseudo edge
  task automatic pulse(input logic ov);
    quantizedSumVideo <= 1;
    repeat (20) @(posedge clk);
    if (ov) begin
      overlapStep <= 1;
      @(posedge clk);
      while (pseudoEdgeDecl !== 1'b1) @(posedge clk);
      overlapStep <= 0;
    end
    repeat (20) @(posedge clk);
    quantizedSumVideo <= 0;
    repeat (20) @(posedge clk);
  endtask

  // Recorder role: every record is read whole, low word first
  task automatic drain();
    logic [63:0] rec;
    int          n, nP, nPs, nSw;
    nP = 0;
    nPs = 0;
    nSw = 0;
    apb(0, `REG_STATUS, 32'h0, 32'h0, 32'h0, 0);
    n = rd[9:0];
    for (int i = 0; i < n; i++) begin
      apb(0, `REG_DATA_LO, 32'h0, 32'h0, 32'h0, 0);
      rec[31:0] = rd;
      apb(0, `REG_DATA_HI, 32'h0, 32'h0, 32'h0, 0);
      rec[63:32] = rd;
      if (i == 0) begin
        chk({30'h0, rec[63:62]}, {30'h0, `TAG_HEADER});
        chk(rec[31:0], param);
      end else if (rec[63:62] == `TAG_PULSE && sampQ.size() > 0) begin
        nP++;
        nPs += rec[61];
        chk({4'h0, rec[36:9]}, {4'h0, sampQ.pop_front()});
      end else if (rec[63:62] == `TAG_SWEEP) begin
        nSw++;
        if (nSw == 1)
          chk({9'h0, rec[54:32]}, {10'h0, xmitMode, azPrimary, 2'h0});
        else
          chk({9'h0, rec[54:32]}, {9'h0, 1'b1, xmitMode, azSynchro});
      end
    end
    chk(32'(nP), 32'(nStrobe));
    chk(32'(nPs), 32'h0000_0001);
    chk(32'(nSw > 0), 32'h0000_0001);
  endtask

  task automatic summarize();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Output watchers
  // ****************************************************************
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      expE = expQ.pop_front();
      chk(prdata & expE[63:32], expE[31:0]);
      chk({31'h0, pslverr}, {31'h0, expE[64]});
    end
  end

  always @(posedge clk) begin
    cyc     <= cyc + 1;
    strobeD <= encodeStrobe;
    if (encodeStrobe === 1'b1) begin
      nStrobe <= nStrobe + 1;
      chk({31'h0, strobeD}, 32'h0);
    end
    if (leadEdgeDecl === 1'b1) nLead <= nLead + 1;
    if (pseudoEdgeDecl === 1'b1) nPseudo <= nPseudo + 1;
    if (strobeD === 1'b1) sampQ.push_back(convData);
    if (zeroRangeTrig === 1'b1) begin
      zrGap  <= cyc - zrLast;
      zrLast <= cyc;
      nZr    <= nZr + 1;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {quantizedSumVideo, overlapStep, preambleHit} = '0;
    {snrOk, riseOk, azPrimaryValid} = 3'h7;
    seed = 87;
    azPrimary = '0;
    azSynchro = '0;
    xmitMode = '0;
    rst_b = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    apb(0, `REG_INTERVAL, 32'h0, 32'h0000_FFFF, {16'h0, `INTERVAL_RST}, 0);
    apb(0, `REG_REP, 32'h0, 32'h000F_FFFF, {12'h0, `REP_RST}, 0);
    apb(0, 8'h20, 32'h0, 32'hFFFF_FFFF, 32'h0, 1);
    apb(1, `REG_REP, 32'h0000_0100, 32'h0, 32'h0, 0);
    apb(0, `REG_REP, 32'h0, 32'h000F_FFFF, 32'h0000_0100, 0);
    seed = xs(seed);
    param = seed;
    apb(1, `REG_PARAM, param, 32'h0, 32'h0, 0);
    seed = xs(seed);
    azPrimary <= seed[13:0];
    azSynchro <= seed[29:14];
    xmitMode  <= seed[5:0] ^ seed[31:26];
    qSel = (seed[31:30] == 2'h3) ? 2'h2 : seed[31:30];
    apb(1, `REG_CTRL, {28'h0, qSel, 2'h1}, 32'h0, 32'h0, 0);
    s0 = nStrobe;
    l0 = nLead;
    pulse(0);
    pulse(1);
    chk(32'(nStrobe - s0), 32'h0000_0003);
    chk(32'(nLead - l0), 32'h0000_0002);
    chk(32'(nPseudo), 32'h0000_0001);
    apb(1, `REG_CTRL, {28'h0, ((qSel == 2'h2) ? 2'h0 : qSel + 2'h1), 2'h3},
        32'h0, 32'h0, 0);
    pulse(0);
    repeat (440) @(posedge clk);
    pulse(0);
    repeat (488) @(posedge clk);
    apb(0, `REG_STATUS, 32'h0, 32'h0000_0400, 32'h0000_0400, 0);
    repeat (25) @(posedge clk);
    apb(0, `REG_STATUS, 32'h0, 32'h0000_0400, 32'h0, 0);
    apb(1, `REG_CTRL, {28'h0, ((qSel == 2'h0) ? 2'h2 : qSel - 2'h1), 2'h3},
        32'h0, 32'h0, 0);
    preambleHit <= 1;
    @(posedge clk);
    preambleHit <= 0;
    repeat (185) @(posedge clk);
    apb(0, `REG_STATUS, 32'h0, 32'h0000_0400, 32'h0000_0400, 0);
    repeat (20) @(posedge clk);
    apb(0, `REG_STATUS, 32'h0, 32'h0000_0400, 32'h0, 0);
    // Second sweep is taken from the backup azimuth source
    azPrimaryValid <= 0;
    while (nZr < 2) @(posedge clk);
    chk(32'(zrGap >= 796 && zrGap <= 804), 32'h0000_0001);
    drain();
    summarize();
  end
endmodule // tb_top
